// file: dtc_chk.sv
// Checker of the dual timer/counter: APB answer timing and flag clearing.
// Assumes it is bound to dtc_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module dtc_chk (
	// Clock and reset.
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// APB.
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic [31:0] prdata_out,
	// Flags.
	input wire logic [3:0] int_ack_in,
	input wire logic [1:0] overflow_flag_out
);
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	wire logic wr_done = psel_in && penable_in && pready_out && pwrite_in;
	ready_pulse_a: assert property (pready_out |=> !pready_out) else $error("ready too long");
	one_wait_a: assert property (psel_in && penable_in && !pready_out |=> pready_out) else $error("late");
	ready_cause_a: assert property (pready_out |-> $past(psel_in && penable_in)) else $error("no access");
	err_with_ready_a: assert property (pslverr_out |-> pready_out) else $error("stray error");
	idle_data_a: assert property (!pready_out |-> prdata_out == 32'h0) else $error("idle data");
	byte_data_a: assert property (pready_out |-> prdata_out[31:8] == 24'h0) else $error("upper data");
	ovf0_clear_a: assert property ($fell(overflow_flag_out[0]) |-> $past(int_ack_in[0] || wr_done))
		else $error("flag 0 lost");
	ovf1_clear_a: assert property ($fell(overflow_flag_out[1]) |-> $past(int_ack_in[1] || wr_done))
		else $error("flag 1 lost");
endmodule
bind dtc_top dtc_chk i_chk (.ref_clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .pready_out,
	.pslverr_out, .prdata_out, .int_ack_in, .overflow_flag_out);
`default_nettype wire

// file: dtc_core.sv
// One timer's count bytes and their mode-dependent increment logic.
// Assumes increment requests are single-cycle enables on the same clock.
`timescale 1ns/10ps
`default_nettype none
module dtc_core #(
	parameter bit SPLIT_EN = 1'b1
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Control.
	input wire logic [1:0] mode_in,
	input wire logic inc_lo_in,
	input wire logic inc_hi_in,
	// Software preset.
	input wire logic wr_lo_in,
	input wire logic wr_hi_in,
	input wire logic [7:0] wdata_in,
	// Count and overflow pulses.
	output logic [7:0] lo_out,
	output logic [7:0] hi_out,
	output logic ovf_out,
	output logic ovf_hi_out
);
	dtc_pkg::dtc_byte_t lo_q, lo_d, hi_q, hi_d;
	logic ovf_d, ovf_hi_d;
	wire lo_full = (lo_q == 8'hFF);
	wire hi_full = (hi_q == 8'hFF);
	wire pre_full = (lo_q[4:0] == 5'h1F);
	wire dtc_pkg::dtc_mode_e mode = dtc_pkg::dtc_mode_e'(mode_in);

	always_comb begin
		lo_d = lo_q;
		hi_d = hi_q;
		ovf_d = 1'b0;
		ovf_hi_d = 1'b0;
		unique case (mode)
			dtc_pkg::DTC_M13: begin
				if (inc_lo_in) begin
					lo_d[4:0] = lo_q[4:0] + 5'h01;
					if (pre_full) begin
						hi_d = hi_q + 8'h01;
						ovf_d = hi_full;
					end
				end
			end
			dtc_pkg::DTC_M16: begin
				if (inc_lo_in) begin
					{hi_d, lo_d} = {hi_q, lo_q} + 16'h0001;
					ovf_d = lo_full & hi_full;
				end
			end
			dtc_pkg::DTC_MRELOAD: begin
				if (inc_lo_in) begin
					lo_d = lo_full ? hi_q : lo_q + 8'h01;
					ovf_d = lo_full;
				end
			end
			dtc_pkg::DTC_MSPLIT: begin
				if (SPLIT_EN) begin
					if (inc_lo_in) begin
						lo_d = lo_q + 8'h01;
						ovf_d = lo_full;
					end
					if (inc_hi_in) begin
						hi_d = hi_q + 8'h01;
						ovf_hi_d = hi_full;
					end
				end
			end
		endcase
		if (wr_lo_in) begin
			lo_d = wdata_in;
		end
		if (wr_hi_in) begin
			hi_d = wdata_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lo_q <= dtc_pkg::CNT_RST;
			hi_q <= dtc_pkg::CNT_RST;
		end else begin
			lo_q <= lo_d;
			hi_q <= hi_d;
		end
	end

	assign lo_out = lo_q;
	assign hi_out = hi_q;
	assign ovf_out = ovf_d;
	assign ovf_hi_out = ovf_hi_d;
endmodule
`default_nettype wire

// file: dtc_pin_model.sv
// Model of the count and gate pins beside the timers.
// Assumes the bench calls its tasks; pins change just after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module dtc_pin_model (
	// Clock.
	input wire logic clk_in,
	// Pins.
	output logic [1:0] count_pin_out,
	output logic [1:0] gate_pin_out
);
	initial begin
		count_pin_out = 2'h3;
		gate_pin_out = 2'h3;
	end
	// Each level stands for hold clocks, the high level one clock more; the task sets no floor.
	task automatic pulse(input int idx, input int n, input int hold);
		repeat (n) begin
			@(posedge clk_in) count_pin_out[idx] <= 1'b0;
			repeat (hold) @(posedge clk_in);
			count_pin_out[idx] <= 1'b1;
			repeat (hold) @(posedge clk_in);
		end
	endtask
	task automatic gate(input int idx, input logic v);
		@(posedge clk_in) gate_pin_out[idx] <= v;
	endtask
endmodule
`default_nettype wire

// file: dtc_pkg.sv
// Package of the dual timer/counter: register offsets, field positions,
// reset values, mode encoding and the peripheral cycle length.
// Assumes a 32-bit APB slave with one aligned word per register.
package dtc_pkg;

	// Register byte offsets.
	localparam logic [7:0] OFF_MODE = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h04;
	localparam logic [7:0] OFF_LO0 = 8'h08;
	localparam logic [7:0] OFF_HI0 = 8'h0C;
	localparam logic [7:0] OFF_LO1 = 8'h10;
	localparam logic [7:0] OFF_HI1 = 8'h14;
	localparam logic [7:0] OFF_STAT = 8'h18;
	localparam logic [7:0] OFF_MASK = 8'h1C;

	// Control register bit positions.
	localparam int CTRL_TYPE0 = 0;
	localparam int CTRL_EXT0 = 1;
	localparam int CTRL_TYPE1 = 2;
	localparam int CTRL_EXT1 = 3;
	localparam int CTRL_RUN0 = 4;
	localparam int CTRL_OVF0 = 5;
	localparam int CTRL_RUN1 = 6;
	localparam int CTRL_OVF1 = 7;

	// Mode register: nibble base per timer, and fields inside a nibble.
	localparam int MODE_T0_LSB = 0;
	localparam int MODE_T1_LSB = 4;
	localparam int MSEL_LSB = 0;
	localparam int SRC_BIT = 2;
	localparam int GATE_BIT = 3;

	// Interrupt status and mask bit positions.
	localparam int EV_OVF0 = 0;
	localparam int EV_OVF1 = 1;
	localparam int EV_EXT0 = 2;
	localparam int EV_EXT1 = 3;
	localparam int EV_W = 4;

	// Reset values.
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] CNT_RST = 8'h00;
	localparam logic [3:0] MASK_RST = 4'h0;
	localparam logic [3:0] STAT_RST = 4'h0;

	// Peripheral clock periods in one peripheral cycle.
	localparam int PER_CLK_DIV = 6;

	typedef logic [7:0] dtc_byte_t;

	typedef enum logic [1:0] {
		DTC_M13 = 2'h0,
		DTC_M16 = 2'h1,
		DTC_MRELOAD = 2'h2,
		DTC_MSPLIT = 2'h3
	} dtc_mode_e;

endpackage

// file: dtc_top.sv
// Dual timer/counter with APB register access, pin synchronisers,
// peripheral-cycle divider and a masked interrupt output.
// Assumes one clock; count and gate pins are asynchronous to it.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Low and high bytes cascade into 16 bits.
// - Run bit enables counting of selected source.
// - Setting run bit keeps the count bytes.
// - Counts readable anytime; preset only when stopped.
// - Source select: 0 clock, 1 pin falls.
// - Clock counting once per six-period cycle.
// - Pin sampled per cycle; high-then-low counts.
// - Gate enable adds gate pin to run bit.
// - Rollover to zero sets overflow flag.
// - Timer 0 mode nibble and control bits.
// - Mode 0: 5-bit prescaler feeds high byte.
// - Mode 2: low byte reloads from high.
// - Mode 3: timer 0 splits in two.
// - Timer 1 upper nibble; mode 3 holds.
module dtc_top #(
	parameter int PER_DIV = dtc_pkg::PER_CLK_DIV
) (
	// Clock and reset.
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// APB slave.
	input wire logic [7:0] paddr_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// External pins.
	input wire logic [1:0] count_pin_in,
	input wire logic [1:0] gate_pin_in,
	// Interrupt vector acknowledge per event, one-cycle pulses.
	input wire logic [3:0] int_ack_in,
	// Interrupt requests.
	output logic [1:0] overflow_flag_out,
	output logic [1:0] ext_irq_flag_out,
	output logic irq_out
);
	// Reset release through two flip-flops.
	logic rst_s1_q, rst_s2_q;
	wire rst_n = rst_s2_q;

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	// Register address decode.
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		hit = (addr == off);
	endfunction

	// Counting is allowed by the run bit, and by the gate pin when gating is on.
	function automatic logic cnt_enable(input logic run, input logic gate_on, input logic gate_high);
		cnt_enable = run & (~gate_on | gate_high);
	endfunction

	// The selected source is a fall seen on the count pin or the peripheral tick.
	function automatic logic cnt_strobe(input logic en, input logic pin_src, input logic fall, input logic tick);
		cnt_strobe = en & (pin_src ? fall : tick);
	endfunction

	// Registers.
	logic [7:0] mode_q, ctrl_q, ctrl_d;
	logic [3:0] stat_q, stat_d, mask_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q, irq_q;

	// Peripheral cycle divider, sized so that any PER_DIV fits.
	localparam int DIV_W = (PER_DIV > 2) ? $clog2(PER_DIV) : 1;
	logic [DIV_W-1:0] div_q;
	wire per_tick = (div_q == DIV_W'(PER_DIV - 1));

	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= {DIV_W{1'b0}};
		end else if (per_tick) begin
			div_q <= {DIV_W{1'b0}};
		end else begin
			div_q <= div_q + DIV_W'(1);
		end
	end

	// Pin synchronisers: {gate_pin_in, count_pin_in}, i.e. {gate1, gate0, count1, count0}.
	// They reset high, the idle level of the pins, so no false fall follows reset.
	logic [3:0] pin_s1_q, pin_s2_q;
	logic [1:0] samp_q, gate_prev_q;

	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_q <= 4'hF;
			pin_s2_q <= 4'hF;
		end else begin
			pin_s1_q <= {gate_pin_in, count_pin_in};
			pin_s2_q <= pin_s1_q;
		end
	end

	// Count pins are sampled once per peripheral cycle.
	// A low reset sample means no fall can be counted before the first sample.
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			samp_q <= 2'h0;
		end else if (per_tick) begin
			samp_q <= pin_s2_q[1:0];
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			gate_prev_q <= 2'h3;
		end else begin
			gate_prev_q <= pin_s2_q[3:2];
		end
	end

	wire [1:0] cnt_lvl = pin_s2_q[1:0];
	wire [1:0] gate_lvl = pin_s2_q[3:2];
	// Previous sample high and present sample low counts one event.
	wire [1:0] cnt_fall = {2{per_tick}} & samp_q & ~cnt_lvl;
	wire [1:0] gate_fall = gate_prev_q & ~gate_lvl;

	// Field extraction.
	wire [3:0] nib0 = mode_q[dtc_pkg::MODE_T0_LSB +: 4];
	wire [3:0] nib1 = mode_q[dtc_pkg::MODE_T1_LSB +: 4];
	wire [1:0] msel0 = nib0[dtc_pkg::MSEL_LSB +: 2];
	wire [1:0] msel1 = nib1[dtc_pkg::MSEL_LSB +: 2];
	wire src0 = nib0[dtc_pkg::SRC_BIT];
	wire src1 = nib1[dtc_pkg::SRC_BIT];
	wire gate_enable_t0 = nib0[dtc_pkg::GATE_BIT];
	wire gate_enable_t1 = nib1[dtc_pkg::GATE_BIT];
	wire run0 = ctrl_q[dtc_pkg::CTRL_RUN0];
	wire run1 = ctrl_q[dtc_pkg::CTRL_RUN1];
	wire split0 = (msel0 == 2'(dtc_pkg::DTC_MSPLIT));

	// Counting enables and increment strobes.
	wire en0 = cnt_enable(run0, gate_enable_t0, gate_lvl[0]);
	// With timer 0 split, timer 1 loses its run bit and counts whenever its gate allows.
	wire run1_eff = split0 | run1;
	wire en1 = cnt_enable(run1_eff, gate_enable_t1, gate_lvl[1]);
	wire inc0 = cnt_strobe(en0, src0, cnt_fall[0], per_tick);
	wire inc1 = cnt_strobe(en1, src1, cnt_fall[1], per_tick);
	// The split high byte counts ticks under timer 1's run bit, with no gate.
	wire inc0_hi = run1 & per_tick;

	// APB access decode: one wait state, completion on pready.
	wire acc = psel_in & penable_in;
	wire done = acc & pready_q;
	wire wr = done & pwrite_in;
	wire sel_mode = hit(paddr_in, dtc_pkg::OFF_MODE);
	wire sel_ctrl = hit(paddr_in, dtc_pkg::OFF_CTRL);
	wire sel_lo0 = hit(paddr_in, dtc_pkg::OFF_LO0);
	wire sel_hi0 = hit(paddr_in, dtc_pkg::OFF_HI0);
	wire sel_lo1 = hit(paddr_in, dtc_pkg::OFF_LO1);
	wire sel_hi1 = hit(paddr_in, dtc_pkg::OFF_HI1);
	wire sel_stat = hit(paddr_in, dtc_pkg::OFF_STAT);
	wire sel_mask = hit(paddr_in, dtc_pkg::OFF_MASK);
	wire mapped = sel_mode | sel_ctrl | sel_lo0 | sel_hi0 | sel_lo1 | sel_hi1 | sel_stat | sel_mask;
	wire [7:0] wbyte = pwdata_in[7:0];

	// Register write strobes.
	wire wr_mode = wr & sel_mode;
	wire wr_ctrl = wr & sel_ctrl;
	wire wr_lo0 = wr & sel_lo0;
	wire wr_hi0 = wr & sel_hi0;
	wire wr_lo1 = wr & sel_lo1;
	wire wr_hi1 = wr & sel_hi1;
	wire wr_stat = wr & sel_stat;
	wire wr_mask = wr & sel_mask;

	// Timer cores.
	wire [7:0] lo0, hi0, lo1, hi1;
	wire ovf0, ovf0_hi, ovf1;

	// Presets land directly; software keeps the timer stopped meanwhile.
	dtc_core #(
		.SPLIT_EN(1'b1)
	) u_core0 (
		.clk_in(ref_clk_in),
		.rst_n_in(rst_n),
		.mode_in(msel0),
		.inc_lo_in(inc0),
		.inc_hi_in(inc0_hi),
		.wr_lo_in(wr_lo0),
		.wr_hi_in(wr_hi0),
		.wdata_in(wbyte),
		.lo_out(lo0),
		.hi_out(hi0),
		.ovf_out(ovf0),
		.ovf_hi_out(ovf0_hi)
	);

	// Timer 1 holds its count in mode 3.
	dtc_core #(
		.SPLIT_EN(1'b0)
	) u_core1 (
		.clk_in(ref_clk_in),
		.rst_n_in(rst_n),
		.mode_in(msel1),
		.inc_lo_in(inc1),
		.inc_hi_in(1'b0),
		.wr_lo_in(wr_lo1),
		.wr_hi_in(wr_hi1),
		.wdata_in(wbyte),
		.lo_out(lo1),
		.hi_out(hi1),
		.ovf_out(ovf1),
		.ovf_hi_out()
	);

	// Overflow sources; split mode hands timer 1's flag to timer 0's high byte.
	wire set_ovf0 = ovf0;
	wire set_ovf1 = split0 ? ovf0_hi : ovf1;
	wire type0 = ctrl_q[dtc_pkg::CTRL_TYPE0];
	wire type1 = ctrl_q[dtc_pkg::CTRL_TYPE1];
	wire [3:0] events = {gate_fall[1], gate_fall[0], set_ovf1, set_ovf0};

	// Control register next state: software write, then acknowledge clear,
	// then hardware set, so a set in the clearing cycle is kept.
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d = wbyte;
		end
		if (int_ack_in[dtc_pkg::EV_OVF0]) begin
			ctrl_d[dtc_pkg::CTRL_OVF0] = 1'b0;
		end
		if (int_ack_in[dtc_pkg::EV_OVF1]) begin
			ctrl_d[dtc_pkg::CTRL_OVF1] = 1'b0;
		end
		if (int_ack_in[dtc_pkg::EV_EXT0] & type0) begin
			ctrl_d[dtc_pkg::CTRL_EXT0] = 1'b0;
		end
		if (int_ack_in[dtc_pkg::EV_EXT1] & type1) begin
			ctrl_d[dtc_pkg::CTRL_EXT1] = 1'b0;
		end
		if (set_ovf0) begin
			ctrl_d[dtc_pkg::CTRL_OVF0] = 1'b1;
		end
		if (set_ovf1) begin
			ctrl_d[dtc_pkg::CTRL_OVF1] = 1'b1;
		end
		// Edge type latches a falling edge; level type follows a low pin.
		if (type0) begin
			ctrl_d[dtc_pkg::CTRL_EXT0] = ctrl_d[dtc_pkg::CTRL_EXT0] | gate_fall[0];
		end else begin
			ctrl_d[dtc_pkg::CTRL_EXT0] = ~gate_lvl[0];
		end
		if (type1) begin
			ctrl_d[dtc_pkg::CTRL_EXT1] = ctrl_d[dtc_pkg::CTRL_EXT1] | gate_fall[1];
		end else begin
			ctrl_d[dtc_pkg::CTRL_EXT1] = ~gate_lvl[1];
		end
	end

	// Sticky status: write one to clear, a new event wins.
	always_comb begin
		stat_d = stat_q;
		if (wr_stat) begin
			stat_d = stat_q & ~pwdata_in[3:0];
		end
		stat_d = stat_d | events;
	end

	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= dtc_pkg::MODE_RST;
			ctrl_q <= dtc_pkg::CTRL_RST;
			stat_q <= dtc_pkg::STAT_RST;
			mask_q <= dtc_pkg::MASK_RST;
		end else begin
			if (wr_mode) begin
				mode_q <= wbyte;
			end
			if (wr_mask) begin
				mask_q <= pwdata_in[3:0];
			end
			ctrl_q <= ctrl_d;
			stat_q <= stat_d;
		end
	end

	// Read data selection.
	wire [7:0] rbyte =
		sel_mode ? mode_q :
		sel_ctrl ? ctrl_q :
		sel_lo0 ? lo0 :
		sel_hi0 ? hi0 :
		sel_lo1 ? lo1 :
		sel_hi1 ? hi1 :
		sel_stat ? {4'h0, stat_q} :
		sel_mask ? {4'h0, mask_q} : 8'h00;

	// APB answer: pready rises in the first access cycle's following edge.
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else if (acc & ~pready_q) begin
			pready_q <= 1'b1;
			pslverr_q <= ~mapped;
			prdata_q <= pwrite_in ? 32'h0000_0000 : {24'h00_0000, rbyte};
		end else begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
	end

	// Interrupt output.
	wire irq_d = |(stat_q & mask_q);
	always_ff @(posedge ref_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	assign prdata_out = prdata_q;
	assign pready_out = pready_q;
	assign pslverr_out = pslverr_q;
	assign irq_out = irq_q;
	assign overflow_flag_out = {ctrl_q[dtc_pkg::CTRL_OVF1], ctrl_q[dtc_pkg::CTRL_OVF0]};
	assign ext_irq_flag_out = {ctrl_q[dtc_pkg::CTRL_EXT1], ctrl_q[dtc_pkg::CTRL_EXT0]};
endmodule
`default_nettype wire

// file: tb_dual_timer_counter.sv
// Bench of the dual timer/counter: registers, count modes, overflow, interrupt.
// Assumes dtc_top, dtc_pin_model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
`define chk(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
	$display("mismatch at %0t: got %0h exp %0h", $time, a, b); end end
module tb_dual_timer_counter;
	logic ref_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] ack = 4'h0;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, irq;
	wire logic [1:0] cpin, gpin, ovf, ext;
	logic [31:0] d;
	logic e;
	logic [1:0] flg;
	int err_count = 0;
	int samples_checked = 0;
	always #5 ref_clk_in = ~ref_clk_in;
	dtc_top i_dtc_top (.ref_clk_in, .rst_n_in, .paddr_in(paddr), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .count_pin_in(cpin), .gate_pin_in(gpin), .int_ack_in(ack),
		.overflow_flag_out(ovf), .ext_irq_flag_out(ext), .irq_out(irq));
	dtc_pin_model i_pins (.clk_in(ref_clk_in), .count_pin_out(cpin), .gate_pin_out(gpin));
	task automatic test_done();
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] v);
		int i;
		@(posedge ref_clk_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, v};
		@(posedge ref_clk_in);
		penable <= 1'b1;
		for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge ref_clk_in);
		if (pready !== 1'b1) begin
			err_count++;
			test_done();
		end
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] x);
		apb(1'b0, a, 8'h00);
		`chk(d, {24'h0, x})
	endtask
	task automatic setup(input logic [7:0] m, lo, hi, a);
		apb(1'b1, dtc_pkg::OFF_CTRL, 8'h00);
		apb(1'b1, dtc_pkg::OFF_MODE, m);
		apb(1'b1, a, lo);
		apb(1'b1, a + 8'h04, hi);
	endtask
	// Run window between the two control writes is n + 4 clocks.
	task automatic go(input logic [7:0] c, input int n);
		apb(1'b1, dtc_pkg::OFF_CTRL, c);
		repeat (n) @(posedge ref_clk_in);
		flg = ovf;
		apb(1'b1, dtc_pkg::OFF_CTRL, 8'h00);
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask
	task automatic s_regs();
		logic [7:0] a;
		for (a = 8'h00; a < 8'h20; a += 8'h04) rchk(a, 8'h00);
		apb(1'b0, 8'h20, 8'h00);
		`chk(e, 1'b1)
		apb(1'b1, dtc_pkg::OFF_MODE, 8'h5A);
		rchk(dtc_pkg::OFF_MODE, 8'h5A);
	endtask
	task automatic s_rate();
		setup(8'h01, 8'h10, 8'h00, dtc_pkg::OFF_LO0);
		go(8'h10, 56);
		rchk(dtc_pkg::OFF_LO0, 8'h1A);
		wait_clk(30);
		rchk(dtc_pkg::OFF_LO0, 8'h1A);
	endtask
	task automatic s_modes();
		setup(8'h00, 8'hFE, 8'h05, dtc_pkg::OFF_LO0);
		go(8'h10, 20);
		rchk(dtc_pkg::OFF_LO0, 8'hE2);
		rchk(dtc_pkg::OFF_HI0, 8'h06);
		setup(8'h02, 8'hFE, 8'hF0, dtc_pkg::OFF_LO0);
		go(8'h10, 20);
		rchk(dtc_pkg::OFF_LO0, 8'hF2);
		rchk(dtc_pkg::OFF_HI0, 8'hF0);
		`chk(flg[0], 1'b1)
		setup(8'h03, 8'h00, 8'hFD, dtc_pkg::OFF_LO0);
		go(8'h40, 20);
		rchk(dtc_pkg::OFF_HI0, 8'h01);
		rchk(dtc_pkg::OFF_LO0, 8'h00);
		`chk(flg[1], 1'b1)
	endtask
	task automatic s_t1();
		setup(8'h10, 8'hFE, 8'hFF, dtc_pkg::OFF_LO1);
		go(8'h40, 20);
		rchk(dtc_pkg::OFF_LO1, 8'h02);
		`chk(flg, 2'h2)
		setup(8'h30, 8'h55, 8'h66, dtc_pkg::OFF_LO1);
		go(8'h40, 20);
		rchk(dtc_pkg::OFF_LO1, 8'h55);
	endtask
	task automatic s_irq();
		int i;
		setup(8'h01, 8'hFD, 8'hFF, dtc_pkg::OFF_LO0);
		apb(1'b1, dtc_pkg::OFF_STAT, 8'h0F);
		rchk(dtc_pkg::OFF_STAT, 8'h00);
		apb(1'b1, dtc_pkg::OFF_MASK, 8'h01);
		wait_clk(2);
		`chk(irq, 1'b0)
		apb(1'b1, dtc_pkg::OFF_CTRL, 8'h10);
		for (i = 0; i < 100 && ovf[0] !== 1'b1; i++) @(posedge ref_clk_in);
		if (ovf[0] !== 1'b1) begin
			err_count++;
			test_done();
		end
		wait_clk(2);
		`chk(irq, 1'b1)
		rchk(dtc_pkg::OFF_CTRL, 8'h30);
		apb(1'b1, dtc_pkg::OFF_CTRL, 8'h20);
		rchk(dtc_pkg::OFF_HI0, 8'h00);
		@(posedge ref_clk_in) ack <= 4'h1;
		@(posedge ref_clk_in) ack <= 4'h0;
		wait_clk(1);
		`chk(ovf[0], 1'b0)
		rchk(dtc_pkg::OFF_STAT, 8'h01);
		apb(1'b1, dtc_pkg::OFF_MASK, 8'h00);
		wait_clk(2);
		`chk(irq, 1'b0)
		apb(1'b1, dtc_pkg::OFF_MASK, 8'h01);
		apb(1'b1, dtc_pkg::OFF_STAT, 8'h01);
		wait_clk(2);
		`chk(irq, 1'b0)
		apb(1'b1, dtc_pkg::OFF_MASK, 8'h00);
	endtask
	task automatic s_count();
		int h;
		for (h = 6; h < 20; h += 7) begin
			setup(8'h05, 8'h00, 8'h00, dtc_pkg::OFF_LO0);
			apb(1'b1, dtc_pkg::OFF_CTRL, 8'h10);
			i_pins.pulse(0, 5, h);
			wait_clk(20);
			apb(1'b1, dtc_pkg::OFF_CTRL, 8'h00);
			rchk(dtc_pkg::OFF_LO0, 8'h05);
		end
	endtask
	task automatic s_gate();
		i_pins.gate(0, 1'b0);
		setup(8'h09, 8'h00, 8'h00, dtc_pkg::OFF_LO0);
		`chk(ext[0], 1'b1)
		rchk(dtc_pkg::OFF_STAT, 8'h04);
		go(8'h10, 56);
		rchk(dtc_pkg::OFF_LO0, 8'h00);
		i_pins.gate(0, 1'b1);
		go(8'h10, 56);
		rchk(dtc_pkg::OFF_LO0, 8'h0A);
		`chk(ext[0], 1'b0)
		apb(1'b1, dtc_pkg::OFF_CTRL, 8'h01);
		i_pins.gate(0, 1'b0);
		wait_clk(6);
		i_pins.gate(0, 1'b1);
		wait_clk(6);
		`chk(ext[0], 1'b1)
		@(posedge ref_clk_in) ack <= 4'h4;
		@(posedge ref_clk_in) ack <= 4'h0;
		wait_clk(1);
		`chk(ext[0], 1'b0)
	endtask
	initial begin
		wait_clk(10);
		rst_n_in <= 1'b1;
		wait_clk(3);
		s_regs();
		s_rate();
		s_modes();
		s_t1();
		s_irq();
		s_count();
		s_gate();
		test_done();
	end
endmodule
`default_nettype wire
